/* File: src/gpcfg_pkg.sv */
package gpcfg_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int GPCFG_GROUPS   = 2;
  localparam int GPCFG_PINS     = 32;
  localparam int GPCFG_ADDR_W   = 8;
  localparam int GPCFG_DATA_W   = 32;
  localparam int GPCFG_SYNC_LEN = 2;

  // ----------------------------------------------------------------
  // address map, one register set per group
  // ----------------------------------------------------------------
  localparam logic [GPCFG_ADDR_W-1:0] GPCFG_GROUP_STRIDE = 8'h80;
  localparam logic [GPCFG_ADDR_W-1:0] GPCFG_GROUP0_BASE  = 8'h00;
  localparam int                      GPCFG_OFF_W        = 7;

  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_DIR        = 7'h00;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_DIR_CLR    = 7'h04;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_DIR_SET    = 7'h08;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_DIR_TGL    = 7'h0C;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_LEVEL      = 7'h10;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_LEVEL_CLR  = 7'h14;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_LEVEL_SET  = 7'h18;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_LEVEL_TGL  = 7'h1C;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_PIN_VALUE  = 7'h20;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_DRIVE_STAT = 7'h24;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_PULL_STAT  = 7'h28;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_SETUP_BASE = 7'h40;
  localparam logic [GPCFG_OFF_W-1:0] GPCFG_OFF_SETUP_LAST = 7'h5C;

  // ----------------------------------------------------------------
  // pin_setup_reg layout: one byte per pin, four pins per word
  // ----------------------------------------------------------------
  localparam int GPCFG_SETUP_BYTE_W   = 8;
  localparam int GPCFG_PINS_PER_WORD  = 4;
  localparam int GPCFG_BIT_INBUF      = 1;
  localparam int GPCFG_BIT_PULL       = 2;

  localparam logic [GPCFG_DATA_W-1:0] GPCFG_RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------
  function automatic logic gpcfg_group_of(input logic [GPCFG_ADDR_W-1:0] a);
    gpcfg_group_of = (a >= (GPCFG_GROUP0_BASE + GPCFG_GROUP_STRIDE));
  endfunction

  function automatic logic [GPCFG_OFF_W-1:0] gpcfg_offset_of(input logic [GPCFG_ADDR_W-1:0] a);
    gpcfg_offset_of = a[GPCFG_OFF_W-1:0];
  endfunction

  function automatic logic gpcfg_is_setup(input logic [GPCFG_OFF_W-1:0] o);
    gpcfg_is_setup = (o >= GPCFG_OFF_SETUP_BASE) && (o <= GPCFG_OFF_SETUP_LAST);
  endfunction

  function automatic logic [2:0] gpcfg_setup_word(input logic [GPCFG_OFF_W-1:0] o);
    logic [GPCFG_OFF_W-1:0] rel;
    rel = o - GPCFG_OFF_SETUP_BASE;
    gpcfg_setup_word = rel[4:2];
  endfunction

endpackage

/* File: src/gpcfg_sync.sv */
`timescale 1ns/1ps
module gpcfg_sync
  import gpcfg_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [GPCFG_PINS-1:0] pin_async,
  output logic      [GPCFG_PINS-1:0] pin_sync
);

  // ----------------------------------------------------------------
  // two-stage synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [GPCFG_PINS-1:0] meta;
    logic [GPCFG_PINS-1:0] stable;
  } gpcfg_sync_t;

  gpcfg_sync_t s_q;
  gpcfg_sync_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.meta   = pin_async;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_sync = s_q.stable;

endmodule // gpcfg_sync

/* File: src/gpcfg_pad_ctrl.sv */
`timescale 1ns/1ps
module gpcfg_pad_ctrl
  import gpcfg_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [GPCFG_PINS-1:0] dir_next,
  input  wire logic [GPCFG_PINS-1:0] level_next,
  input  wire logic [GPCFG_PINS-1:0] inbuf_next,
  input  wire logic [GPCFG_PINS-1:0] pull_next,
  output logic      [GPCFG_PINS-1:0] pad_oe_n,
  output logic      [GPCFG_PINS-1:0] pad_out,
  output logic      [GPCFG_PINS-1:0] pad_pull_en,
  output logic      [GPCFG_PINS-1:0] pad_pull_up,
  output logic      [GPCFG_PINS-1:0] pad_in_en
);

  // ----------------------------------------------------------------
  // pad state, decoded from the next configuration so the pads move
  // on the same edge as the configuration registers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [GPCFG_PINS-1:0] oe_n;
    logic [GPCFG_PINS-1:0] out;
    logic [GPCFG_PINS-1:0] pull_en;
    logic [GPCFG_PINS-1:0] pull_up;
    logic [GPCFG_PINS-1:0] in_en;
  } gpcfg_pad_t;

  gpcfg_pad_t s_q;
  gpcfg_pad_t s_d;

  always_comb begin
    s_d         = s_q;
    s_d.oe_n    = ~dir_next;
    // level forced low when not driving, keeps the pad quiet
    s_d.out     = dir_next & level_next;
    s_d.pull_en = ~dir_next & pull_next;
    s_d.pull_up = ~dir_next & pull_next & level_next;
    s_d.in_en   = inbuf_next;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q      <= '0;
      s_q.oe_n <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pad_oe_n    = s_q.oe_n;
  assign pad_out     = s_q.out;
  assign pad_pull_en = s_q.pull_en;
  assign pad_pull_up = s_q.pull_up;
  assign pad_in_en   = s_q.in_en;

endmodule // gpcfg_pad_ctrl

/* File: src/gpcfg_top.sv */
`timescale 1ns/1ps
module gpcfg_top
  import gpcfg_pkg::*;
(
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  input  wire logic [GPCFG_ADDR_W-1:0]                 reg_addr,
  input  wire logic [GPCFG_DATA_W-1:0]                 reg_wdata,
  input  wire logic                                    reg_we,
  input  wire logic                                    reg_re,
  output logic      [GPCFG_DATA_W-1:0]                 reg_rdata,
  input  wire logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_in,
  output logic      [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_oe_n,
  output logic      [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_out,
  output logic      [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_pull_en,
  output logic      [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_pull_up,
  output logic      [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_in_en
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pin_output_select;
    logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] drive_level_bit;
    logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] input_buffer_on;
    logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pull_resistor_on;
    logic [GPCFG_DATA_W-1:0]                 rdata;
  } gpcfg_state_t;

  gpcfg_state_t s_q;
  gpcfg_state_t s_d;

  logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pin_value;
  logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] drive_now;
  logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pull_now;

  logic                   acc_group;
  logic [GPCFG_OFF_W-1:0] acc_off;
  logic                   acc_aligned;
  logic [2:0]             acc_word;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  always_comb begin
    acc_group   = gpcfg_group_of(reg_addr);
    acc_off     = gpcfg_offset_of(reg_addr);
    acc_aligned = (reg_addr[1:0] == 2'h0);
    acc_word    = gpcfg_setup_word(acc_off);
  end

  // ----------------------------------------------------------------
  // pin_setup_reg word packing: four pins, one byte each
  // ----------------------------------------------------------------
  function automatic logic [GPCFG_DATA_W-1:0] pack_setup(
    input logic [GPCFG_PINS-1:0] inbuf,
    input logic [GPCFG_PINS-1:0] pull,
    input logic [2:0]            word
  );
    logic [GPCFG_DATA_W-1:0] w;
    logic [4:0]              pin;
    w = '0;
    for (int k = 0; k < GPCFG_PINS_PER_WORD; k++) begin
      pin = {word, k[1:0]};
      w[k*GPCFG_SETUP_BYTE_W + GPCFG_BIT_INBUF] = inbuf[pin];
      w[k*GPCFG_SETUP_BYTE_W + GPCFG_BIT_PULL]  = pull[pin];
    end
    pack_setup = w;
  endfunction

  // ----------------------------------------------------------------
  // register writes and reads
  // ----------------------------------------------------------------
  always_comb begin
    logic [GPCFG_PINS-1:0] dir_w;
    logic [GPCFG_PINS-1:0] lvl_w;
    logic [GPCFG_PINS-1:0] inb_w;
    logic [GPCFG_PINS-1:0] pul_w;
    logic [4:0]            pin;
    dir_w = s_q.pin_output_select[acc_group];
    lvl_w = s_q.drive_level_bit[acc_group];
    inb_w = s_q.input_buffer_on[acc_group];
    pul_w = s_q.pull_resistor_on[acc_group];
    pin   = 5'h00;
    s_d       = s_q;
    s_d.rdata = GPCFG_RESET_WORD;

    if (reg_we && acc_aligned) begin
      unique case (acc_off)
        GPCFG_OFF_DIR:       dir_w = reg_wdata;
        GPCFG_OFF_DIR_CLR:   dir_w = dir_w & ~reg_wdata;
        GPCFG_OFF_DIR_SET:   dir_w = dir_w | reg_wdata;
        GPCFG_OFF_DIR_TGL:   dir_w = dir_w ^ reg_wdata;
        GPCFG_OFF_LEVEL:     lvl_w = reg_wdata;
        GPCFG_OFF_LEVEL_CLR: lvl_w = lvl_w & ~reg_wdata;
        GPCFG_OFF_LEVEL_SET: lvl_w = lvl_w | reg_wdata;
        GPCFG_OFF_LEVEL_TGL: lvl_w = lvl_w ^ reg_wdata;
        default: begin
          // pull lives here only, so direction writes never touch it
          if (gpcfg_is_setup(acc_off)) begin
            for (int k = 0; k < GPCFG_PINS_PER_WORD; k++) begin
              pin        = {acc_word, k[1:0]};
              inb_w[pin] = reg_wdata[k*GPCFG_SETUP_BYTE_W + GPCFG_BIT_INBUF];
              pul_w[pin] = reg_wdata[k*GPCFG_SETUP_BYTE_W + GPCFG_BIT_PULL];
            end
          end
        end
      endcase
      s_d.pin_output_select[acc_group] = dir_w;
      s_d.drive_level_bit[acc_group]   = lvl_w;
      s_d.input_buffer_on[acc_group]   = inb_w;
      s_d.pull_resistor_on[acc_group]  = pul_w;
    end

    if (reg_re && acc_aligned) begin
      unique case (acc_off)
        GPCFG_OFF_DIR,
        GPCFG_OFF_DIR_CLR,
        GPCFG_OFF_DIR_SET,
        GPCFG_OFF_DIR_TGL:    s_d.rdata = s_q.pin_output_select[acc_group];
        GPCFG_OFF_LEVEL,
        GPCFG_OFF_LEVEL_CLR,
        GPCFG_OFF_LEVEL_SET,
        GPCFG_OFF_LEVEL_TGL:  s_d.rdata = s_q.drive_level_bit[acc_group];
        GPCFG_OFF_PIN_VALUE:  s_d.rdata = pin_value[acc_group];
        GPCFG_OFF_DRIVE_STAT: s_d.rdata = drive_now[acc_group];
        GPCFG_OFF_PULL_STAT:  s_d.rdata = pull_now[acc_group];
        default: begin
          if (gpcfg_is_setup(acc_off)) begin
            s_d.rdata = pack_setup(s_q.input_buffer_on[acc_group],
                                   s_q.pull_resistor_on[acc_group], acc_word);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;

  // ----------------------------------------------------------------
  // per-group pad control and input sampling
  // ----------------------------------------------------------------
  for (genvar g = 0; g < GPCFG_GROUPS; g++) begin : g_group
    logic [GPCFG_PINS-1:0] in_sync;

    gpcfg_pad_ctrl u_pad (
      .clk         (clk),
      .rst         (rst),
      .dir_next    (s_d.pin_output_select[g]),
      .level_next  (s_d.drive_level_bit[g]),
      .inbuf_next  (s_d.input_buffer_on[g]),
      .pull_next   (s_d.pull_resistor_on[g]),
      .pad_oe_n    (pad_oe_n[g]),
      .pad_out     (pad_out[g]),
      .pad_pull_en (pad_pull_en[g]),
      .pad_pull_up (pad_pull_up[g]),
      .pad_in_en   (pad_in_en[g])
    );

    gpcfg_sync u_sync (
      .clk       (clk),
      .rst       (rst),
      .pin_async (pad_in[g]),
      .pin_sync  (in_sync)
    );

    // buffer off reads as zero, whatever the pin does
    assign pin_value[g] = in_sync & s_q.input_buffer_on[g];
    assign drive_now[g] = ~pad_oe_n[g];
    assign pull_now[g]  = pad_pull_en[g];
  end

endmodule // gpcfg_top

/* File: sim/gpcfg_pad_model.sv */
`timescale 1ns/1ps
module gpcfg_pad_model
  import gpcfg_pkg::*;
(
  input  wire logic                                    clk,
  input  wire logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_oe_n,
  input  wire logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_out,
  input  wire logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_pull_en,
  input  wire logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_pull_up,
  output logic      [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_in
);
  logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] drift_q = '0;
  // a floating pin must not read as a steady level
  always_ff @(posedge clk) begin
    drift_q <= ~drift_q;
  end
  // driver beats pull, pull beats float
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & pad_pull_en & pad_pull_up) |
                  (pad_oe_n & ~pad_pull_en & drift_q);
endmodule // gpcfg_pad_model

/* File: sim/gpcfg_chk.sv */
`timescale 1ns/1ps
module gpcfg_chk
  import gpcfg_pkg::*;
(
  input wire logic                                    clk,
  input wire logic                                    rst,
  input wire logic [GPCFG_ADDR_W-1:0]                 reg_addr,
  input wire logic [GPCFG_DATA_W-1:0]                 reg_wdata,
  input wire logic                                    reg_we,
  input wire logic                                    reg_re,
  input wire logic [GPCFG_DATA_W-1:0]                 reg_rdata,
  input wire logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_oe_n,
  input wire logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_out,
  input wire logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_pull_en,
  input wire logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_pull_up,
  input wire logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_in_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  drive_no_pull_a: assert property ((~pad_oe_n & pad_pull_en) == '0)
    else $error("pull on while driving");
  up_needs_pull_a: assert property ((pad_pull_up & ~pad_pull_en) == '0)
    else $error("pull-up without pull");
  idle_out_low_a: assert property ((pad_out & pad_oe_n) == '0)
    else $error("level shown on undriven pin");
  reset_safe_a: assert property ($fell(rst) |-> pad_oe_n == '1 && pad_in_en == '0 && pad_pull_en == '0)
    else $error("pads not safe after reset");
  rdata_idle_a: assert property (!reg_re |=> reg_rdata == '0)
    else $error("read data without read");
  dir_set_a: assert property (reg_we && reg_addr == 8'h08 |=> (pad_oe_n[0] & $past(reg_wdata)) == '0)
    else $error("set direction did not drive");
  dir_clr_a: assert property (reg_we && reg_addr == 8'h84 |=> (~pad_oe_n[1] & $past(reg_wdata)) == '0)
    else $error("cleared direction still drives");
  drive_stat_a: assert property (reg_re && reg_addr == 8'h24 |=> reg_rdata == ~$past(pad_oe_n[0]))
    else $error("drive status mismatch");
  pull_stat_a: assert property (reg_re && reg_addr == 8'hA8 |=> reg_rdata == $past(pad_pull_en[1]))
    else $error("pull status mismatch");
  pin_mask_a: assert property (reg_re && reg_addr == 8'h20 |=> (reg_rdata & ~$past(pad_in_en[0])) == '0)
    else $error("pin value seen with buffer off");
  hold_pads_a: assert property (!reg_we |=> $stable(pad_oe_n) && $stable(pad_pull_en) && $stable(pad_in_en))
    else $error("pads moved without a write");
  cover property (reg_we && reg_addr == 8'h08);
  cover property (reg_re && reg_addr == 8'h20);
  cover property ($fell(rst));
endmodule // gpcfg_chk

bind gpcfg_top gpcfg_chk chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pad_oe_n(pad_oe_n), .pad_out(pad_out),
  .pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up), .pad_in_en(pad_in_en));

/* File: sim/gpio_pin_configuration_tb.sv */
`timescale 1ns/1ps
module gpio_pin_configuration_tb
  import gpcfg_pkg::*;
;
  logic                                    clk = 1'b0;
  logic                                    rst = 1'b1;
  logic                                    reg_we = 1'b0;
  logic                                    reg_re = 1'b0;
  logic [GPCFG_ADDR_W-1:0]                 reg_addr = '0;
  logic [GPCFG_DATA_W-1:0]                 reg_wdata = '0;
  logic [GPCFG_DATA_W-1:0]                 reg_rdata;
  logic [GPCFG_GROUPS-1:0][GPCFG_PINS-1:0] pad_in, oe_n, pout, pen, pup, ien, dir_m, lvl_m;
  int                                      fail_count = 0;
  int                                      n_tests = 0;
  int                                      cyc = 0;

  always #4 clk = ~clk;

  gpcfg_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_oe_n(oe_n), .pad_out(pout),
    .pad_pull_en(pen), .pad_pull_up(pup), .pad_in_en(ien));
  gpcfg_pad_model pad_u (.clk(clk), .pad_oe_n(oe_n), .pad_out(pout), .pad_pull_en(pen),
    .pad_pull_up(pup), .pad_in(pad_in));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t register got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pad(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t pad got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_re <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_we <= 1'b0;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      reg_we <= 1'b0;
      reg_re <= 1'b0;
    end
    #1;
  endtask
  // {oe_n, out, pull_en, pull_up, in_en}
  function automatic logic [4:0] exp_pad(input logic d, input logic l, input logic i, input logic p);
    return {~d, d & l, ~d & p, ~d & p & l, i};
  endfunction
  task automatic chk_safe();
    cmp(oe_n[0] & oe_n[1], '1);
    cmp(ien[0] | ien[1] | pen[0] | pen[1], '0);
    cmp(pout[0] | pout[1] | pup[0] | pup[1], '0);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0]  b;
    int          g, q;
    logic        d, l, i, p;
    void'($urandom(32'h321f40b7));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    chk_safe();
    for (g = 0; g < 2; g++) begin
      b = 8'(g * 128);
      dir_m[g] = $urandom;
      lvl_m[g] = $urandom;
      wr(b, dir_m[g]);
      wr(b + 8'h10, lvl_m[g]);
    end
    wr(8'h01, '1);
    rd(8'h30, r);
    cmp(r, '0);
    for (g = 0; g < 2; g++) begin
      rd(8'(g * 128), r);
      cmp(r, dir_m[g]);
    end
    for (int k = 0; k < 32; k++) begin
      {d, i, p, l} = 4'(k);
      g = $urandom_range(1);
      q = $urandom_range(31);
      b = 8'(g * 128);
      wr(b + 8'h40 + 8'((q / 4) * 4), {29'h0, p, i, 1'b0} << (8 * (q % 4)));
      wr(b + (d ? 8'h08 : 8'h04), 32'h1 << q);
      if (l != lvl_m[g][q]) wr(b + 8'h1C, 32'h1 << q);
      dir_m[g][q] = d;
      lvl_m[g][q] = l;
      // pads settle and the two-flop synchroniser catches up
      idle(3);
      cmp_pad({oe_n[g][q], pout[g][q], pen[g][q], pup[g][q], ien[g][q]}, exp_pad(d, l, i, p));
      rd(b, r);
      cmp(r, dir_m[g]);
      rd(b + 8'h10, r);
      cmp(r, lvl_m[g]);
      rd(b + 8'h24, r);
      cmp({31'h0, r[q]}, {31'h0, d});
      rd(b + 8'h28, r);
      cmp({31'h0, r[q]}, {31'h0, ~d & p});
      rd(b + 8'h20, r);
      if (d | p | ~i) cmp({31'h0, r[q]}, {31'h0, i & l});
    end
    // toggle, set and clear strobes that the loop never reaches
    wr(8'h0C, 32'hFFFF_0000);
    wr(8'h98, 32'h0000_00FF);
    wr(8'h94, 32'h0000_000F);
    dir_m[0] = dir_m[0] ^ 32'hFFFF_0000;
    lvl_m[1] = (lvl_m[1] | 32'h0000_00FF) & ~32'h0000_000F;
    rd(8'h00, r);
    cmp(r, dir_m[0]);
    rd(8'h90, r);
    cmp(r, lvl_m[1]);
    cmp(~oe_n[0], dir_m[0]);
    cmp(pout[1], dir_m[1] & lvl_m[1]);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    idle(1);
    chk_safe();
    rd(8'h00, r);
    cmp(r, '0);
    stop_test();
  end
endmodule // gpio_pin_configuration_tb
